//--- charger_defs.vh
// constants shared by the charger mode and thermistor control block
`ifndef CHARGER_DEFS_VH
`define CHARGER_DEFS_VH

// post-termination status hold: 20 s of the 10 MHz clock, sized to its counter
`define STATUS_HOLD_CYC   28'hBEBC200

// top-off stage: 45 minutes of the 10 MHz clock, sized to its counter
`define TOPOFF_CYC        36'h649534E00

// counter widths sized to hold the cycle counts above
`define STATUS_CNT_W      28
`define TOPOFF_CNT_W      36

// synchronised input vector layout
`define SYN_W             14
`define SYN_MODE_HIGH     0
`define SYN_MODE_LOW      1
`define SYN_ABOVE_ABSENT  2
`define SYN_ABOVE_COLD    3
`define SYN_ABOVE_COLD_H  4
`define SYN_BELOW_HOT     5
`define SYN_BELOW_HOT_H   6
`define SYN_BELOW_DIS     7
`define SYN_UNDERVOLTAGE_LOCKOUT_OK       8
`define SYN_OVP_TRIP      9
`define SYN_TERM_CURR     10
`define SYN_RECHARGE      11
`define SYN_PROG_SUPPLY   12
`define SYN_PROG_GND      13

// controller states, one-hot
`define ST_W              4
`define ST_OFF            4'h1
`define ST_CHARGE         4'h2
`define ST_TOPOFF         4'h4
`define ST_MONITOR        4'h8

`endif

//--- charger_mode_ntc_control.v
// control logic of a single-cell charger: mode decode, cycle states, status
//
// Functional notes
// RULE_01 - high mode level selects USB high power
// RULE_02 - mid mode level selects USB low power
// RULE_03 - low mode level selects adapter mode
// RULE_04 - host drives 0, 1, or floats mode
// RULE_05 - mode input idle when off, disabled, monitoring
// RULE_06 - monitor after termination or top-off expiry
// RULE_07 - recharge threshold in monitor restarts charging
// RULE_08 - auto recharge keeps status released, timer runs
// RULE_09 - disable then enable starts a new cycle
// RULE_10 - host holds disable one instruction cycle
// RULE_11 - forced cycle status held 20 s past termination
// RULE_12 - program pin at supply picks fixed timer
// RULE_13 - temperature fault: output off, timer frozen, flags
// RULE_14 - hysteresis on both temperature thresholds
// RULE_15 - back in range: resume timer, both flags
// RULE_16 - timer counts output on-time only
// RULE_17 - thermistor classified into ratio ranges
// RULE_18 - disable range: off, timer reset, status released
// RULE_19 - host may disable charger at any time
// RULE_20 - disabled: source flag still tracks supply validity
// RULE_21 - absent battery: no timer, regulate, status released
// RULE_22 - leaving absent range resets the timer
// RULE_23 - cold and hot faults handled identically
// RULE_24 - termination on current below tenth of fast
// RULE_25 - top-off lasts 45 minutes then monitor
// RULE_26 - all comparator inputs synchronised first
// RULE_27 - disable over absent over temperature fault
`timescale 1ns/1ns
`include "charger_defs.vh"
module charger_mode_ntc_control #(
    parameter [`STATUS_CNT_W-1:0] STATUS_HOLD_CYCLES = `STATUS_HOLD_CYC,
    parameter [`TOPOFF_CNT_W-1:0] TOPOFF_CYCLES      = `TOPOFF_CYC
) (
    input  wire clock_i,
    input  wire rst_i,
    input  wire mode_high_i,
    input  wire mode_low_i,
    input  wire ntc_above_absent_i,
    input  wire ntc_above_cold_i,
    input  wire ntc_above_cold_rel_i,
    input  wire ntc_below_hot_i,
    input  wire ntc_below_hot_rel_i,
    input  wire ntc_below_disable_i,
    input  wire supply_above_undervoltage_lockout_i,
    input  wire supply_above_ovp_i,
    input  wire term_current_low_i,
    input  wire battery_below_recharge_i,
    input  wire timer_program_at_supply_i,
    input  wire timer_program_grounded_i,
    output reg  mode_usb_high_o,
    output reg  mode_usb_low_o,
    output reg  mode_adapter_o,
    output reg  mode_input_active_o,
    output reg  charge_enable_o,
    output reg  timer_enable_o,
    output reg  timer_fixed_sel_o,
    output reg  timer_suspend_o,
    output reg  timer_reset_o,
    output reg  topoff_active_o,
    output reg  monitor_active_o,
    output reg  no_battery_o,
    output reg  source_present_flag_o,
    output reg  charge_status_flag_o
);

////////////////////////////////////////////////////////////////////////////////
// synchronise every comparator and level input before any decision
// a disable pulse that covers no rising clock edge is not seen

wire [`SYN_W-1:0] raw_in;
wire [`SYN_W-1:0] syn;

assign raw_in = {timer_program_grounded_i,
                 timer_program_at_supply_i,
                 battery_below_recharge_i,
                 term_current_low_i,
                 supply_above_ovp_i,
                 supply_above_undervoltage_lockout_i,
                 ntc_below_disable_i,
                 ntc_below_hot_rel_i,
                 ntc_below_hot_i,
                 ntc_above_cold_rel_i,
                 ntc_above_cold_i,
                 ntc_above_absent_i,
                 mode_low_i,
                 mode_high_i};

input_sync #(
    .WIDTH (`SYN_W)
) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (raw_in), // RULE_26
    .sync_o  (syn)
);

wire range_disabled;
wire range_absent;
wire range_fault;
wire range_ok;

ntc_classifier u_ntc (
    .clock_i          (clock_i),
    .rst_i            (rst_i),
    .above_absent_i   (syn[`SYN_ABOVE_ABSENT]),
    .above_cold_i     (syn[`SYN_ABOVE_COLD]),
    .above_cold_h_i   (syn[`SYN_ABOVE_COLD_H]),
    .below_hot_i      (syn[`SYN_BELOW_HOT]),
    .below_hot_h_i    (syn[`SYN_BELOW_HOT_H]),
    .below_dis_i      (syn[`SYN_BELOW_DIS]),
    .range_disabled_o (range_disabled),
    .range_absent_o   (range_absent),
    .range_fault_o    (range_fault),
    // the ok range is implied by the other three
    .range_ok_o       ()
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function [`TOPOFF_CNT_W-1:0] count_down;
    input [`TOPOFF_CNT_W-1:0] value;
    begin
        if (value == {`TOPOFF_CNT_W{1'b0}})
            count_down = value;
        else
            count_down = value - {{(`TOPOFF_CNT_W-1){1'b0}}, 1'b1};
    end
endfunction

wire source_ok;
wire timer_on;
wire term_s;
wire recharge_s;

assign source_ok  = syn[`SYN_UNDERVOLTAGE_LOCKOUT_OK] && !syn[`SYN_OVP_TRIP];
// a grounded program pin turns the timer off; absent battery does too
assign timer_on   = !syn[`SYN_PROG_GND] && !range_absent; // RULE_21
assign term_s     = syn[`SYN_TERM_CURR]; // RULE_24
assign recharge_s = syn[`SYN_RECHARGE];

////////////////////////////////////////////////////////////////////////////////
// cycle state machine
// leaving off always starts a forced cycle; only a recharge from
// monitor is automatic, and that one lights the status only on a temperature fault

reg [`ST_W-1:0]         state_reg;
reg [`ST_W-1:0]         state_next;
reg                     auto_reg;
reg                     auto_next;
reg [`TOPOFF_CNT_W-1:0] topoff_cnt_reg;
reg [`TOPOFF_CNT_W-1:0] topoff_cnt_next;
reg                     new_cycle;
reg                     terminated;
reg                     absent_prev_reg;

wire fault_active;
wire running;

assign running      = (state_reg == `ST_CHARGE) || (state_reg == `ST_TOPOFF);
assign fault_active = running && range_fault; // RULE_13 RULE_23

always @* begin
    state_next      = state_reg;
    auto_next       = auto_reg;
    topoff_cnt_next = topoff_cnt_reg;
    new_cycle       = 1'b0;
    terminated      = 1'b0;
    if (!source_ok || range_disabled) begin
        // disable is honoured from any state, three register stages late
        state_next = `ST_OFF; // RULE_18 RULE_19
    end else begin
        case (state_reg)
            `ST_OFF: begin
                // re-enable or fresh supply always starts a forced cycle
                state_next = `ST_CHARGE; // RULE_09
                auto_next  = 1'b0;
                new_cycle  = 1'b1;
            end
            `ST_CHARGE: begin
                if (term_s && !range_absent && !range_fault) begin
                    terminated = 1'b1;
                    if (timer_on) begin
                        state_next      = `ST_TOPOFF;
                        topoff_cnt_next = TOPOFF_CYCLES; // RULE_25
                    end else begin
                        state_next = `ST_MONITOR; // RULE_06
                    end
                end
            end
            `ST_TOPOFF: begin
                if (!timer_on && !range_absent) begin
                    state_next = `ST_MONITOR; // RULE_06
                end else if (!range_fault) begin
                    // a suspended output does not age the top-off stage
                    topoff_cnt_next = count_down(topoff_cnt_reg); // RULE_16
                    if (topoff_cnt_reg <= {{(`TOPOFF_CNT_W-1){1'b0}}, 1'b1})
                        state_next = `ST_MONITOR; // RULE_06 RULE_25
                end
            end
            `ST_MONITOR: begin
                if (recharge_s) begin
                    state_next = `ST_CHARGE; // RULE_07
                    auto_next  = 1'b1; // RULE_08
                    new_cycle  = 1'b1;
                end
            end
            default: begin
                state_next = `ST_OFF;
            end
        endcase
    end
end

always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        state_reg       <= `ST_OFF;
        auto_reg        <= 1'b0;
        topoff_cnt_reg  <= {`TOPOFF_CNT_W{1'b0}};
        absent_prev_reg <= 1'b0;
    end else begin
        state_reg       <= state_next;
        auto_reg        <= auto_next;
        topoff_cnt_reg  <= topoff_cnt_next;
        absent_prev_reg <= range_absent;
    end
end

////////////////////////////////////////////////////////////////////////////////
// charging status with post-termination hold

reg                     status_reg;
reg [`STATUS_CNT_W-1:0] hold_cnt_reg;

// true while the post-termination hold is still counting
function hold_live;
    input [`STATUS_CNT_W-1:0] value;
    begin
        hold_live = (value != {`STATUS_CNT_W{1'b0}});
    end
endfunction

always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        status_reg   <= 1'b0;
        hold_cnt_reg <= {`STATUS_CNT_W{1'b0}};
    end else if (state_next == `ST_OFF) begin
        status_reg   <= 1'b0; // RULE_18
        hold_cnt_reg <= {`STATUS_CNT_W{1'b0}};
    end else if (new_cycle) begin
        // automatic recharge clears the indication and its hold
        status_reg   <= !auto_next; // RULE_08 RULE_11
        hold_cnt_reg <= {`STATUS_CNT_W{1'b0}};
    end else if (terminated && status_reg) begin
        hold_cnt_reg <= STATUS_HOLD_CYCLES; // RULE_11
    end else if (hold_live(hold_cnt_reg)) begin
        hold_cnt_reg <= hold_cnt_reg - {{(`STATUS_CNT_W-1){1'b0}}, 1'b1};
        if (hold_cnt_reg == {{(`STATUS_CNT_W-1){1'b0}}, 1'b1})
            status_reg <= 1'b0; // RULE_11
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode decode; level ignored and last mode kept while the input is idle

reg mode_active_next;

always @* begin
    // follows the registered state so it moves in step with the monitor flag
    mode_active_next = source_ok && !range_disabled && running; // RULE_05
end

always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        // lowest current is the safe default
        mode_usb_high_o     <= 1'b0;
        mode_usb_low_o      <= 1'b1;
        mode_adapter_o      <= 1'b0;
        mode_input_active_o <= 1'b0;
    end else begin
        mode_input_active_o <= mode_active_next; // RULE_05
        if (mode_input_active_o) begin
            mode_usb_high_o <= syn[`SYN_MODE_HIGH]; // RULE_01
            mode_adapter_o  <= !syn[`SYN_MODE_HIGH]
                               && syn[`SYN_MODE_LOW]; // RULE_03
            mode_usb_low_o  <= !syn[`SYN_MODE_HIGH]
                               && !syn[`SYN_MODE_LOW]; // RULE_02
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// status and timer-reset decode

wire status_charging;
wire status_holding;
wire leave_absent;

// a forced cycle shows status while it charges, then for the hold after it ends
assign status_charging = status_reg && running && !range_absent && !range_disabled; // RULE_11
assign status_holding  = status_reg && hold_live(hold_cnt_reg) && !range_absent; // RULE_11
// reinstalling the battery restarts the stage timer from zero
assign leave_absent    = absent_prev_reg && !range_absent; // RULE_22

////////////////////////////////////////////////////////////////////////////////
// charger, timer and status outputs

always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        charge_enable_o       <= 1'b0;
        timer_enable_o        <= 1'b0;
        timer_fixed_sel_o     <= 1'b0;
        timer_suspend_o       <= 1'b0;
        timer_reset_o         <= 1'b1;
        topoff_active_o       <= 1'b0;
        monitor_active_o      <= 1'b0;
        no_battery_o          <= 1'b0;
        source_present_flag_o <= 1'b0;
        charge_status_flag_o  <= 1'b0;
    end else begin
        // absent battery keeps regulating; a fault turns the output off
        charge_enable_o   <= running && !range_fault; // RULE_13 RULE_15 RULE_21
        timer_enable_o    <= timer_on; // RULE_21
        timer_fixed_sel_o <= syn[`SYN_PROG_SUPPLY]; // RULE_12
        timer_suspend_o   <= fault_active; // RULE_13 RULE_15 RULE_16
        timer_reset_o     <= (state_reg == `ST_OFF) // RULE_18
                             || new_cycle || terminated
                             || leave_absent; // RULE_22
        topoff_active_o   <= state_reg == `ST_TOPOFF;
        monitor_active_o  <= state_reg == `ST_MONITOR;
        no_battery_o      <= range_absent;
        // supply validity shows even while disabled
        source_present_flag_o <= source_ok && !fault_active; // RULE_13 RULE_15 RULE_20 RULE_21
        charge_status_flag_o  <= fault_active || status_charging
                                 || status_holding; // RULE_11 RULE_13 RULE_21
    end
end

endmodule

//--- charger_mode_ntc_control_sva.sv
// concurrent checks on the charger control ports
`timescale 1ns/1ns
module charger_mode_ntc_control_sva #(
    parameter [27:0] STATUS_HOLD_CYCLES = 28'h32,
    parameter [35:0] TOPOFF_CYCLES      = 36'h64
) (
    input wire clock_i,
    input wire rst_i,
    input wire mode_high_i,
    input wire mode_low_i,
    input wire ntc_below_disable_i,
    input wire supply_above_undervoltage_lockout_i,
    input wire supply_above_ovp_i,
    input wire battery_below_recharge_i,
    input wire mode_usb_high_o,
    input wire mode_usb_low_o,
    input wire mode_adapter_o,
    input wire mode_input_active_o,
    input wire charge_enable_o,
    input wire timer_suspend_o,
    input wire timer_reset_o,
    input wire topoff_active_o,
    input wire monitor_active_o,
    input wire no_battery_o,
    input wire source_present_flag_o,
    input wire charge_status_flag_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    mode_high_a: assert property ((mode_input_active_o && mode_high_i && !mode_low_i)[*5]
        |-> mode_usb_high_o) else $error("high mode not selected");
    mode_mid_a: assert property ((mode_input_active_o && !mode_high_i && !mode_low_i)[*5]
        |-> mode_usb_low_o) else $error("low power mode not selected");
    mode_low_a: assert property ((mode_input_active_o && mode_low_i && !mode_high_i)[*5]
        |-> mode_adapter_o) else $error("adapter mode not selected");
    monitor_idle_a: assert property (monitor_active_o
        |-> !charge_enable_o && !mode_input_active_o) else $error("monitor not idle");
    recharge_exit_a: assert property (monitor_active_o && battery_below_recharge_i
        |-> ##[1:5] !monitor_active_o) else $error("recharge did not start");
    fault_flags_a: assert property (timer_suspend_o
        |-> !charge_enable_o && charge_status_flag_o && !source_present_flag_o)
        else $error("fault outputs wrong");
    disable_off_a: assert property (ntc_below_disable_i[*6]
        |-> !charge_enable_o && !charge_status_flag_o && timer_reset_o)
        else $error("disable not honoured");
    disabled_source_a: assert property ((ntc_below_disable_i && supply_above_undervoltage_lockout_i
        && !supply_above_ovp_i)[*6] |-> source_present_flag_o) else $error("source flag lost");
    no_supply_a: assert property ((!supply_above_undervoltage_lockout_i || supply_above_ovp_i)[*5]
        |-> !source_present_flag_o && !charge_enable_o) else $error("invalid supply charging");
    absent_status_a: assert property (no_battery_o
        |-> !charge_status_flag_o && source_present_flag_o) else $error("absent flags wrong");
    cover property (topoff_active_o ##1 monitor_active_o);
    cover property (timer_suspend_o);
    cover property (no_battery_o);
endmodule
bind charger_mode_ntc_control charger_mode_ntc_control_sva #(
    .STATUS_HOLD_CYCLES(STATUS_HOLD_CYCLES),
    .TOPOFF_CYCLES(TOPOFF_CYCLES)
) sva_i (.clock_i, .rst_i, .mode_high_i, .mode_low_i, .ntc_below_disable_i,
    .supply_above_undervoltage_lockout_i, .supply_above_ovp_i, .battery_below_recharge_i, .mode_usb_high_o,
    .mode_usb_low_o, .mode_adapter_o, .mode_input_active_o, .charge_enable_o,
    .timer_suspend_o, .timer_reset_o, .topoff_active_o, .monitor_active_o, .no_battery_o,
    .source_present_flag_o, .charge_status_flag_o);

//--- charger_mode_ntc_control_tb.sv
// testbench for the charger mode and thermistor control block
`timescale 1ns/1ns
module charger_mode_ntc_control_tb;
    reg        clock_i  = 1'b0;
    reg        rst_i    = 1'b1;
    reg  [1:0] mode_cmd = 2'h2;
    reg  [6:0] ntc_pct  = 7'h32;
    reg        undervoltage_lockout_ok  = 1'b1;
    reg        overvoltage_protect      = 1'b0;
    reg        term     = 1'b0;
    reg        rechg    = 1'b0;
    reg        prog_sup = 1'b1;
    reg        prog_gnd = 1'b0;
    wire       m_hi, m_lo, ab, co, cr, ho, hr, dis;
    wire       u_hi, u_lo, u_ad, m_act, en, t_en, t_fix, t_sus, t_rst, top, mon, nob, src, sts;
    integer    err_total = 0;
    integer    cmp_count = 0;
    integer    i;
    ////////////////////////////////////////////////////////////////////////////////
    host_ntc_model host (.mode_cmd_i(mode_cmd), .ntc_pct_i(ntc_pct), .mode_high_o(m_hi),
        .mode_low_o(m_lo), .above_absent_o(ab), .above_cold_o(co), .above_cold_rel_o(cr),
        .below_hot_o(ho), .below_hot_rel_o(hr), .below_dis_o(dis));
    charger_mode_ntc_control #(.STATUS_HOLD_CYCLES(28'h32), .TOPOFF_CYCLES(36'h64)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .mode_high_i(m_hi), .mode_low_i(m_lo),
        .ntc_above_absent_i(ab), .ntc_above_cold_i(co), .ntc_above_cold_rel_i(cr),
        .ntc_below_hot_i(ho), .ntc_below_hot_rel_i(hr), .ntc_below_disable_i(dis),
        .supply_above_undervoltage_lockout_i(undervoltage_lockout_ok), .supply_above_ovp_i(overvoltage_protect), .term_current_low_i(term),
        .battery_below_recharge_i(rechg), .timer_program_at_supply_i(prog_sup),
        .timer_program_grounded_i(prog_gnd), .mode_usb_high_o(u_hi), .mode_usb_low_o(u_lo),
        .mode_adapter_o(u_ad), .mode_input_active_o(m_act), .charge_enable_o(en),
        .timer_enable_o(t_en), .timer_fixed_sel_o(t_fix), .timer_suspend_o(t_sus),
        .timer_reset_o(t_rst), .topoff_active_o(top), .monitor_active_o(mon),
        .no_battery_o(nob), .source_present_flag_o(src), .charge_status_flag_o(sts));
    always #50 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////////////////////
    // inputs only change at the falling edge, away from the sampling edge
    task cyc(input integer n);
        repeat (n) @(negedge clock_i);
    endtask
    task chk(input logic got, input logic exp, input [8*16-1:0] what);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED at %0t: %0s", $time, what);
        end
    endtask
    task stop_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        cyc(3000);
        err_total = err_total + 1;
        stop_test;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(4);
        rst_i = 1'b0;
        chk(u_lo, 1'b1, "reset mode");
        cyc(8);
        chk(en & sts & src & t_fix, 1'b1, "start");
        chk(u_lo, 1'b1, "mid mode");
        mode_cmd = 2'h1;
        cyc(6);
        chk(u_hi, 1'b1, "high mode");
        mode_cmd = 2'h0;
        cyc(6);
        chk(u_ad, 1'b1, "adapter mode");
        // cold then hot fault, each through its hysteresis band
        for (i = 0; i < 2; i = i + 1) begin
            ntc_pct = i ? 7'h19 : 7'h50;
            cyc(8);
            chk(en | src, 1'b0, "fault off");
            chk(t_sus & sts, 1'b1, "fault flags");
            ntc_pct = i ? 7'h21 : 7'h48;
            cyc(8);
            chk(t_sus, 1'b1, "hysteresis");
            ntc_pct = 7'h32;
            cyc(8);
            chk(en & src & sts & ~t_sus, 1'b1, "resume");
        end
        term = 1'b1;
        cyc(8);
        chk(top, 1'b1, "topoff");
        cyc(22);
        ntc_pct = 7'h50;
        cyc(150);
        ntc_pct = 7'h32;
        cyc(10);
        chk(top, 1'b1, "frozen timer");
        cyc(90);
        chk(mon, 1'b1, "monitor");
        chk(en | m_act, 1'b0, "monitor idle");
        mode_cmd = 2'h1;
        cyc(6);
        chk(u_ad, 1'b1, "mode frozen");
        term = 1'b0;
        rechg = 1'b1;
        cyc(8);
        chk(en & ~sts, 1'b1, "recharge");
        cyc(4);
        chk(u_hi, 1'b1, "mode active");
        rechg = 1'b0;
        term = 1'b1;
        cyc(8);
        chk(top & ~sts, 1'b1, "recharge topoff");
        prog_sup = 1'b0;
        prog_gnd = 1'b1;
        ntc_pct = 7'h05;
        cyc(8);
        chk(en | sts, 1'b0, "disabled");
        chk(t_rst & src & ~t_fix, 1'b1, "disabled src");
        term = 1'b0;
        ntc_pct = 7'h32;
        cyc(8);
        chk(en & sts & ~mon & ~t_en, 1'b1, "forced cycle");
        term = 1'b1;
        cyc(30);
        chk(mon & sts, 1'b1, "status hold");
        cyc(40);
        chk(sts, 1'b0, "status end");
        term = 1'b0;
        ntc_pct = 7'h05;
        cyc(4);
        ntc_pct = 7'h61;
        cyc(8);
        chk(nob & en & src & ~sts & ~t_en, 1'b1, "no battery");
        ntc_pct = 7'h32;
        for (i = 0; i < 10 && t_rst !== 1'b1; i = i + 1) begin
            cyc(1);
        end
        chk(t_rst, 1'b1, "leave absent");
        overvoltage_protect = 1'b1;
        cyc(6);
        chk(src | en, 1'b0, "overvoltage");
        overvoltage_protect = 1'b0;
        undervoltage_lockout_ok = 1'b0;
        cyc(6);
        chk(src | en, 1'b0, "undervoltage");
        stop_test;
    end
endmodule

//--- host_ntc_model.sv
// host gpio and thermistor network model feeding the comparator inputs
`timescale 1ns/1ns
module host_ntc_model (
    input  wire [1:0] mode_cmd_i,
    input  wire [6:0] ntc_pct_i,
    output wire       mode_high_o,
    output wire       mode_low_o,
    output wire       above_absent_o,
    output wire       above_cold_o,
    output wire       above_cold_rel_o,
    output wire       below_hot_o,
    output wire       below_hot_rel_o,
    output wire       below_dis_o
);
    // gpio writes 0 or 1, or turns to input so the pin floats to mid
    assign mode_high_o      = (mode_cmd_i == 2'h1);
    assign mode_low_o       = (mode_cmd_i == 2'h0);
    // release thresholds sit 5 points inside the enter thresholds
    assign above_absent_o   = (ntc_pct_i > 7'h5F);
    assign above_cold_o     = (ntc_pct_i > 7'h4B);
    assign above_cold_rel_o = (ntc_pct_i > 7'h46);
    assign below_hot_o      = (ntc_pct_i < 7'h1E);
    assign below_hot_rel_o  = (ntc_pct_i < 7'h23);
    assign below_dis_o      = (ntc_pct_i < 7'h0A);
endmodule

//--- input_sync.v
// two-flop synchroniser for a vector of comparator and level inputs
`timescale 1ns/1ns
module input_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta_reg;

// first stage is read only by the second
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        meta_reg <= {WIDTH{1'b0}};
        sync_o   <= {WIDTH{1'b0}};
    end else begin
        meta_reg <= async_i;
        sync_o   <= meta_reg;
    end
end

endmodule

//--- ntc_classifier.v
// thermistor range classifier with fault hysteresis and range priority
`timescale 1ns/1ns
module ntc_classifier (
    input  wire clock_i,
    input  wire rst_i,
    input  wire above_absent_i,
    input  wire above_cold_i,
    input  wire above_cold_h_i,
    input  wire below_hot_i,
    input  wire below_hot_h_i,
    input  wire below_dis_i,
    output reg  range_disabled_o,
    output reg  range_absent_o,
    output reg  range_fault_o,
    output reg  range_ok_o
);

reg cold_fault_reg;
reg hot_fault_reg;

////////////////////////////////////////////////////////////////////////////////
// hysteresis: enter past the threshold, leave only past the release level
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        cold_fault_reg <= 1'b0;
        hot_fault_reg  <= 1'b0;
    end else if (above_absent_i || below_dis_i) begin
        // no fault is kept outside the temperature ranges, so none lingers on re-entry
        cold_fault_reg <= 1'b0;
        hot_fault_reg  <= 1'b0;
    end else begin
        if (above_cold_i)
            cold_fault_reg <= 1'b1; // RULE_14
        else if (!above_cold_h_i)
            cold_fault_reg <= 1'b0; // RULE_14
        if (below_hot_i)
            hot_fault_reg <= 1'b1; // RULE_14
        else if (!below_hot_h_i)
            hot_fault_reg <= 1'b0; // RULE_14
    end
end

////////////////////////////////////////////////////////////////////////////////
// disable beats absent battery, which beats either temperature fault
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        range_disabled_o <= 1'b1;
        range_absent_o   <= 1'b0;
        range_fault_o    <= 1'b0;
        range_ok_o       <= 1'b0;
    end else begin
        range_disabled_o <= below_dis_i; // RULE_17 RULE_27
        range_absent_o   <= !below_dis_i && above_absent_i; // RULE_17 RULE_27
        // cold and hot are merged so either network orientation behaves alike
        range_fault_o    <= !below_dis_i && !above_absent_i
                            && (cold_fault_reg || hot_fault_reg); // RULE_23 RULE_27
        range_ok_o       <= !below_dis_i && !above_absent_i
                            && !cold_fault_reg && !hot_fault_reg; // RULE_17
    end
end

endmodule
